//--- src/feir_consts.svh
// Offsets, field positions, reset values and timing counts of the fault response block
`ifndef FEIR_CONSTS_SVH
`define FEIR_CONSTS_SVH
`define FEIR_OFF_FLAGS 8'h00
`define FEIR_OFF_MASK 8'h04
`define FEIR_OFF_LIVE 8'h08
`define FEIR_OFF_CTRL 8'h0C
`define FEIR_OFF_DELAY 8'h10
`define FEIR_NFLAG 10
`define FEIR_B_IRQPIN 0
`define FEIR_B_MCURST 1
`define FEIR_B_SOCRST 2
`define FEIR_B_EMDET 3
`define FEIR_B_EMFAIL 4
`define FEIR_B_EMRST 5
`define FEIR_B_EXTCLK 6
`define FEIR_B_STPASS 7
`define FEIR_B_WDFAIL 8
`define FEIR_B_WDRST 9
`define FEIR_MASKABLE 10'h0FF
`define FEIR_MASK_RST 10'h000
`define FEIR_CTRL_RST 32'h0000_0000
`define FEIR_DELAY_RST 32'h0010_0010
`define FEIR_CLK_NS 8
`define FEIR_WARM_NS 1000
`define FEIR_WARM_CYC ((`FEIR_WARM_NS + `FEIR_CLK_NS - 1) / `FEIR_CLK_NS)
`define FEIR_SHUT_NS 2000
`define FEIR_SHUT_CYC ((`FEIR_SHUT_NS + `FEIR_CLK_NS - 1) / `FEIR_CLK_NS)
`endif

//--- src/feir_pkg.sv
// Types shared by the fault response block
package feir_pkg;
  typedef enum logic [2:0] {
    FEIR_ST_IDLE = 3'b001,
    FEIR_ST_SHUT = 3'b010,
    FEIR_ST_WARM = 3'b100
  } feir_state_e;

  typedef struct packed {
    logic [15:0] unused;
    logic [3:0] wdog_reset_limit;
    logic [3:0] wdog_fail_limit;
    logic [2:0] spare;
    logic wdog_reset_allow;
    logic fail_drops_drive;
    logic pwm_mode;
    logic [1:0] boot_target_state;
  } feir_ctrl_s;
endpackage

//--- src/feir_top.sv
// Fault and event response: flags, masks, pin readback, escalation and warm reset
`timescale 1ns/1ns
`default_nettype none
`include "feir_consts.svh"

// Notes on behaviour
// - Irq pin read low while released: orderly shutdown, gpio low, flag, restart.
// - Mcu reset pin read low while released: same shutdown, restart to boot target.
// - Soc reset pin mismatch only sets flag and live bit, maskable, no transition.
// - Write one clears readback, monitor, clock flags only once condition is gone.
// - Error monitor detect flag: low level, or pwm timing violation; maskable.
// - Fault beyond first delay sets fail flag, optionally drops drive enable.
// - Fault beyond both delays sets reset flag and requests a warm reset.
// - After warm reset the block returns to the operating state held before.
// - Missing or off-range external clock sets maskable flag and live bit.
// - Self-test pass sets a maskable flag cleared by writing one.
// - Watchdog count above fail limit sets unmaskable flag, drops drive enable.
// - Drive enable returns only after fail flag cleared and count no longer above limit.
// - Watchdog count above reset limit sets flag; warm reset only if allowed.
module feir_top #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin readback and monitored pins, asynchronous
  input wire logic irq_pin_sense,
  input wire logic mcu_rst_sense,
  input wire logic soc_rst_sense,
  input wire logic err_signal_in,
  // Event sources on pclk
  input wire logic pwm_violation,
  input wire logic [15:0] pwm_err_count,
  input wire logic [15:0] err_count_limit,
  input wire logic ext_clock_bad,
  input wire logic selftest_pass,
  input wire logic [CNT_W-1:0] wdog_fail_count,
  input wire logic [1:0] op_state,
  // Pins driven
  output logic irq_out_n,
  output logic mcu_reset_out_n,
  output logic soc_reset_out_n,
  output logic drive_enable_out,
  // State machine requests
  output logic regulators_off,
  output logic gpio_low,
  output logic startup_req,
  output logic [1:0] boot_target_state,
  output logic err_mon_reset_req,
  output logic wdog_reset_req,
  output logic restore_req,
  output logic [1:0] restore_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Readback only counts once the released level has had time to reach sync
  function automatic logic feir_rb(input logic [3:0] hist, input logic lvl);
    feir_rb = (&hist) & ~lvl;
  endfunction

  logic [3:0] sy1_r, sy2_r, sy3_r, filt_r;
  logic [3:0] irq_h_r, mcu_h_r, soc_h_r;
  feir_pkg::feir_state_e st_r, st_nxt;
  feir_pkg::feir_ctrl_s ctrl_r;
  logic [31:0] delay_r;
  logic [`FEIR_NFLAG-1:0] flags_r, flags_nxt, mask_r, ev, hold, w1c, pend;
  logic [16:0] esm_cnt_r;
  logic [15:0] tmr_r;
  logic [1:0] saved_r;
  logic irq_c_r, mcu_c_r, wdf_c_r, wdr_c_r, esr_c_r;
  logic irq_c, mcu_c, soc_c, esm_c, fail_c, rst_c, wdf_c, wdr_c;
  logic shut_go, warm_go, tmr_done, wr_en, rd_hit, hit;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy1_r <= 4'hF;
      sy2_r <= 4'hF;
      sy3_r <= 4'hF;
      filt_r <= 4'hF;
    end
    else
    begin
      sy1_r <= {err_signal_in, soc_rst_sense, mcu_rst_sense, irq_pin_sense};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      filt_r <= (sy2_r & sy3_r) | (filt_r & (sy2_r ^ sy3_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditions
  assign irq_c = feir_rb(irq_h_r, filt_r[0]);
  assign mcu_c = feir_rb(mcu_h_r, filt_r[1]);
  assign soc_c = feir_rb(soc_h_r, filt_r[2]);
  assign esm_c = ctrl_r.pwm_mode ? (pwm_err_count > err_count_limit) : ~filt_r[3];
  assign fail_c = esm_cnt_r > {1'b0, delay_r[15:0]};
  assign rst_c = esm_cnt_r > ({1'b0, delay_r[15:0]} + {1'b0, delay_r[31:16]});
  assign wdf_c = wdog_fail_count > ctrl_r.wdog_fail_limit;
  assign wdr_c = wdog_fail_count > ctrl_r.wdog_reset_limit;

  assign ev[`FEIR_B_IRQPIN] = irq_c;
  assign ev[`FEIR_B_MCURST] = mcu_c;
  assign ev[`FEIR_B_SOCRST] = soc_c;
  assign ev[`FEIR_B_EMDET] = ctrl_r.pwm_mode ? pwm_violation : ~filt_r[3];
  assign ev[`FEIR_B_EMFAIL] = fail_c;
  assign ev[`FEIR_B_EMRST] = rst_c & ~esr_c_r;
  assign ev[`FEIR_B_EXTCLK] = ext_clock_bad;
  assign ev[`FEIR_B_STPASS] = selftest_pass;
  assign ev[`FEIR_B_WDFAIL] = wdf_c & ~wdf_c_r;
  assign ev[`FEIR_B_WDRST] = wdr_c & ~wdr_c_r;

  // Flags that refuse a clear while their cause is still present
  assign hold = {3'b000, ext_clock_bad, rst_c, fail_c, esm_c, soc_c, mcu_c, irq_c};
  assign wr_en = psel & penable & pready & pwrite;
  assign w1c = (wr_en && paddr == `FEIR_OFF_FLAGS) ? pwdata[`FEIR_NFLAG-1:0] : '0;
  assign flags_nxt = ev | (flags_r & ~(w1c & ~hold));
  assign pend = flags_r & ~(mask_r & `FEIR_MASKABLE);

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown and warm reset sequencer
  assign shut_go = (irq_c & ~irq_c_r) | (mcu_c & ~mcu_c_r);
  assign warm_go = ev[`FEIR_B_EMRST] | (ev[`FEIR_B_WDRST] & ctrl_r.wdog_reset_allow);
  assign tmr_done = tmr_r == 16'h0000;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      feir_pkg::FEIR_ST_IDLE:
        if (shut_go)
          st_nxt = feir_pkg::FEIR_ST_SHUT;
        else if (warm_go)
          st_nxt = feir_pkg::FEIR_ST_WARM;
      feir_pkg::FEIR_ST_SHUT:
        if (tmr_done)
          st_nxt = feir_pkg::FEIR_ST_IDLE;
      feir_pkg::FEIR_ST_WARM:
        if (tmr_done)
          st_nxt = feir_pkg::FEIR_ST_IDLE;
      default:
        st_nxt = feir_pkg::FEIR_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= feir_pkg::FEIR_ST_IDLE;
      tmr_r <= 16'h0000;
      saved_r <= 2'h0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == feir_pkg::FEIR_ST_IDLE && shut_go)
        tmr_r <= 16'(`FEIR_SHUT_CYC - 1);
      else if (st_r == feir_pkg::FEIR_ST_IDLE && warm_go)
        tmr_r <= 16'(`FEIR_WARM_CYC - 1);
      else if (!tmr_done)
        tmr_r <= tmr_r - 16'h0001;
      if (st_r == feir_pkg::FEIR_ST_IDLE && warm_go)
        saved_r <= op_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, escalation counter and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_r <= '0;
      esm_cnt_r <= 17'h00000;
      {irq_c_r, mcu_c_r, wdf_c_r, wdr_c_r, esr_c_r} <= 5'h00;
    end
    else
    begin
      flags_r <= flags_nxt;
      // Saturates so a long fault never wraps back below the limits
      if (!esm_c)
        esm_cnt_r <= 17'h00000;
      else if (!(&esm_cnt_r))
        esm_cnt_r <= esm_cnt_r + 17'h00001;
      {irq_c_r, mcu_c_r, wdf_c_r, wdr_c_r, esr_c_r} <= {irq_c, mcu_c, wdf_c, wdr_c, rst_c};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and requests, all from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_out_n <= 1'b1;
      mcu_reset_out_n <= 1'b1;
      soc_reset_out_n <= 1'b1;
      drive_enable_out <= 1'b0;
      regulators_off <= 1'b0;
      gpio_low <= 1'b0;
      startup_req <= 1'b0;
      err_mon_reset_req <= 1'b0;
      wdog_reset_req <= 1'b0;
      restore_req <= 1'b0;
      restore_state <= 2'h0;
      irq_h_r <= 4'h0;
      mcu_h_r <= 4'h0;
      soc_h_r <= 4'h0;
    end
    else
    begin
      irq_out_n <= ~|pend;
      mcu_reset_out_n <= st_nxt == feir_pkg::FEIR_ST_IDLE;
      soc_reset_out_n <= st_nxt != feir_pkg::FEIR_ST_WARM;
      drive_enable_out <= st_nxt == feir_pkg::FEIR_ST_IDLE && !flags_r[`FEIR_B_WDFAIL]
        && !wdf_c && !(ctrl_r.fail_drops_drive && flags_r[`FEIR_B_EMFAIL]);
      regulators_off <= st_nxt == feir_pkg::FEIR_ST_SHUT;
      gpio_low <= st_nxt == feir_pkg::FEIR_ST_SHUT;
      startup_req <= st_r == feir_pkg::FEIR_ST_SHUT && tmr_done;
      err_mon_reset_req <= ev[`FEIR_B_EMRST];
      wdog_reset_req <= ev[`FEIR_B_WDRST] & ctrl_r.wdog_reset_allow;
      restore_req <= st_r == feir_pkg::FEIR_ST_WARM && tmr_done;
      restore_state <= saved_r;
      irq_h_r <= {irq_h_r[2:0], irq_out_n};
      mcu_h_r <= {mcu_h_r[2:0], mcu_reset_out_n};
      soc_h_r <= {soc_h_r[2:0], soc_reset_out_n};
    end
  end

  assign boot_target_state = ctrl_r.boot_target_state;

  ////////////////////////////////////////////////////////////////////////////
  // APB: no wait states, answer registered in the setup cycle
  assign hit = paddr == `FEIR_OFF_FLAGS || paddr == `FEIR_OFF_MASK || paddr == `FEIR_OFF_LIVE
    || paddr == `FEIR_OFF_CTRL || paddr == `FEIR_OFF_DELAY;
  assign rd_hit = psel & ~penable;
  assign rd_val =
    paddr == `FEIR_OFF_FLAGS ? {22'h0, flags_r & ~((st_r == feir_pkg::FEIR_ST_WARM) ?
      10'h220 : 10'h000)} :
    paddr == `FEIR_OFF_MASK ? {22'h0, mask_r & `FEIR_MASKABLE} :
    paddr == `FEIR_OFF_LIVE ? {23'h0, st_r, fail_c, esm_c, ext_clock_bad, soc_c, mcu_c, irq_c} :
    paddr == `FEIR_OFF_CTRL ? ctrl_r :
    paddr == `FEIR_OFF_DELAY ? delay_r : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      mask_r <= `FEIR_MASK_RST;
      ctrl_r <= `FEIR_CTRL_RST;
      delay_r <= `FEIR_DELAY_RST;
    end
    else
    begin
      pready <= rd_hit;
      pslverr <= rd_hit & ~hit;
      prdata <= (rd_hit && !pwrite) ? rd_val : 32'h0000_0000;
      if (wr_en && paddr == `FEIR_OFF_MASK)
        mask_r <= pwdata[`FEIR_NFLAG-1:0] & `FEIR_MASKABLE;
      if (wr_en && paddr == `FEIR_OFF_CTRL)
        ctrl_r <= {16'h0000, pwdata[15:0]};
      if (wr_en && paddr == `FEIR_OFF_DELAY)
        delay_r <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_shut_entry;
    st_r == feir_pkg::FEIR_ST_IDLE && shut_go;
  endsequence

  sequence s_shut_body;
    regulators_off && gpio_low && !mcu_reset_out_n;
  endsequence

  a_irq_pin_shut: assert property (@(posedge pclk) disable iff (!presetn)
    s_shut_entry and irq_c |=> s_shut_body ##1 flags_r[`FEIR_B_IRQPIN])
    else $error("irq readback did not start shutdown");
  a_mcu_pin_restart: assert property (@(posedge pclk) disable iff (!presetn)
    s_shut_entry |-> ##`FEIR_SHUT_CYC 1'b1 ##1 startup_req)
    else $error("shutdown did not end in startup request");
  a_soc_pin_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    soc_c && !shut_go && !warm_go && st_r == feir_pkg::FEIR_ST_IDLE
    |=> st_r == feir_pkg::FEIR_ST_IDLE && flags_r[`FEIR_B_SOCRST])
    else $error("soc readback changed state");
  a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    hold[`FEIR_B_EXTCLK] && flags_r[`FEIR_B_EXTCLK] |=> flags_r[`FEIR_B_EXTCLK])
    else $error("flag cleared while cause present");
  a_esm_detect: assert property (@(posedge pclk) disable iff (!presetn)
    ev[`FEIR_B_EMDET] |=> flags_r[`FEIR_B_EMDET])
    else $error("monitor detect flag missing");
  a_esm_fail: assert property (@(posedge pclk) disable iff (!presetn)
    esm_c && esm_cnt_r == {1'b0, delay_r[15:0]} && !(&esm_cnt_r) |=> ##1 flags_r[`FEIR_B_EMFAIL])
    else $error("fail flag not set after first delay");
  a_esm_warm: assert property (@(posedge pclk) disable iff (!presetn)
    ev[`FEIR_B_EMRST] && st_r == feir_pkg::FEIR_ST_IDLE && !shut_go
    |=> err_mon_reset_req && !drive_enable_out && !soc_reset_out_n)
    else $error("monitor warm reset missing");
  a_warm_return: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == feir_pkg::FEIR_ST_WARM && tmr_done |=> restore_req && restore_state == saved_r)
    else $error("warm reset did not restore state");
  a_extclk_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ext_clock_bad |=> flags_r[`FEIR_B_EXTCLK])
    else $error("clock fault flag missing");
  a_selftest_flag: assert property (@(posedge pclk) disable iff (!presetn)
    selftest_pass |=> flags_r[`FEIR_B_STPASS])
    else $error("self-test pass flag missing");
  a_wd_fail_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ev[`FEIR_B_WDFAIL] |=> ##1 !drive_enable_out && flags_r[`FEIR_B_WDFAIL])
    else $error("watchdog fail did not drop drive");
  a_wd_flag_gate: assert property (@(posedge pclk) disable iff (!presetn)
    flags_r[`FEIR_B_WDFAIL] |=> !drive_enable_out)
    else $error("drive enabled while fail flag set");
  a_wd_reset_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ev[`FEIR_B_WDRST] |=> wdog_reset_req == $past(ctrl_r.wdog_reset_allow))
    else $error("watchdog reset request not gated");
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    pend == '0 |=> irq_out_n)
    else $error("masked flag drove irq pin");
  a_irq_active: assert property (@(posedge pclk) disable iff (!presetn)
    pend != '0 |=> !irq_out_n)
    else $error("unmasked flag left irq pin high");

endmodule
`default_nettype wire

//--- sim/feir_host_model.sv
// Host side model: pulled-up readback pins and the monitored error line
`timescale 1ns/1ns
`default_nettype none
module feir_host_model (
  // Pins from the device
  input wire logic irq_out_n,
  input wire logic mcu_reset_out_n,
  input wire logic soc_reset_out_n,
  // Fault injection from the bench
  input wire logic [2:0] pin_short,
  input wire logic err_active,
  // Lines seen by the device
  output logic irq_pin_sense,
  output logic mcu_rst_sense,
  output logic soc_rst_sense,
  output logic err_signal_in
);
  // Pull-up wires: a short to ground wins over a released pin
  assign irq_pin_sense = irq_out_n & ~pin_short[0];
  assign mcu_rst_sense = mcu_reset_out_n & ~pin_short[1];
  assign soc_rst_sense = soc_reset_out_n & ~pin_short[2];
  // Host holds its error line low while its software is faulty
  assign err_signal_in = ~err_active;
endmodule
`default_nettype wire

//--- sim/fault_event_interrupt_response_tb_top.sv
// Self-checking bench of the fault response block
`timescale 1ns/1ns
`default_nettype none
`include "feir_consts.svh"
module fault_event_interrupt_response_tb_top;
  localparam logic [7:0] fl_a = `FEIR_OFF_FLAGS;
  localparam logic [7:0] mask_a = `FEIR_OFF_MASK;
  localparam logic [7:0] live_a = `FEIR_OFF_LIVE;
  localparam logic [7:0] ctrl_a = `FEIR_OFF_CTRL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic pwm_violation, ext_clock_bad, selftest_pass, err_active;
  logic [15:0] pwm_err_count, err_count_limit;
  logic [3:0] wdog_fail_count;
  logic [1:0] op_state, boot_target_state, restore_state, bt;
  logic [2:0] pin_short;
  logic irq_pin_sense, mcu_rst_sense, soc_rst_sense, err_signal_in;
  logic irq_out_n, mcu_reset_out_n, soc_reset_out_n, drive_enable_out;
  logic regulators_off, gpio_low, startup_req, err_mon_reset_req, wdog_reset_req, restore_req;
  int num_errors, tests_run, n, i;
  ////////////////////////////////////////////////////////////////////////////////
  feir_top #(.CNT_W(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pin_sense(irq_pin_sense), .mcu_rst_sense(mcu_rst_sense),
    .soc_rst_sense(soc_rst_sense), .err_signal_in(err_signal_in),
    .pwm_violation(pwm_violation), .pwm_err_count(pwm_err_count),
    .err_count_limit(err_count_limit), .ext_clock_bad(ext_clock_bad),
    .selftest_pass(selftest_pass), .wdog_fail_count(wdog_fail_count), .op_state(op_state),
    .irq_out_n(irq_out_n), .mcu_reset_out_n(mcu_reset_out_n),
    .soc_reset_out_n(soc_reset_out_n), .drive_enable_out(drive_enable_out),
    .regulators_off(regulators_off), .gpio_low(gpio_low), .startup_req(startup_req),
    .boot_target_state(boot_target_state), .err_mon_reset_req(err_mon_reset_req),
    .wdog_reset_req(wdog_reset_req), .restore_req(restore_req), .restore_state(restore_state)
  );
  feir_host_model host (
    .irq_out_n(irq_out_n), .mcu_reset_out_n(mcu_reset_out_n),
    .soc_reset_out_n(soc_reset_out_n), .pin_short(pin_short), .err_active(err_active),
    .irq_pin_sense(irq_pin_sense), .mcu_rst_sense(mcu_rst_sense),
    .soc_rst_sense(soc_rst_sense), .err_signal_in(err_signal_in)
  );
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Master never assumes a latency; a stuck slave counts as a mismatch
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      num_errors++;
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(rq, e, nm);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task test_done;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    num_errors++;
    test_done();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pwm_violation, ext_clock_bad, selftest_pass, err_active, pin_short} = '0;
    pwm_err_count = 16'h0000;
    err_count_limit = 16'h0000;
    wdog_fail_count = 4'h0;
    op_state = 2'h0;
    num_errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    n = $urandom(55);
    cyc(16);
    presetn <= 1'b1;
    // Reset values and an unmapped word
    rd(fl_a, 32'h0000_0000, "flags");
    rd(mask_a, {22'h0, `FEIR_MASK_RST}, "mask");
    rd(ctrl_a, `FEIR_CTRL_RST, "ctrl");
    rd(`FEIR_OFF_DELAY, `FEIR_DELAY_RST, "delay");
    rd(live_a, 32'h0000_0040, "live");
    rd(8'h14, 32'h0000_0000, "unmapped");
    chk(rerr, 1'b1, "pslverr");
    // Self-test pass: flag, pin, mask
    @(posedge pclk) selftest_pass <= 1'b1;
    @(posedge pclk) selftest_pass <= 1'b0;
    cyc(3);
    chk(irq_out_n, 1'b0, "irq pin");
    rd(fl_a, 32'h0000_0080, "pass flag");
    wr(mask_a, 32'h0000_0080);
    cyc(3);
    chk(irq_out_n, 1'b1, "masked pin");
    rd(fl_a, 32'h0000_0080, "masked flag");
    wr(fl_a, 32'h0000_0080);
    wr(mask_a, 32'h0000_0000);
    rd(fl_a, 32'h0000_0000, "pass clear");
    // Interrupt-only level faults: soc pin short, then external clock
    for (i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      pin_short <= (i == 0) ? 3'b100 : 3'b000;
      ext_clock_bad <= (i == 1);
      cyc(6);
      rd(live_a, (i == 0) ? 32'h0000_0044 : 32'h0000_0048, "live");
      chk({regulators_off, mcu_reset_out_n}, 2'b01, "no transition");
      wr(fl_a, 32'h0000_0044);
      rd(fl_a, (i == 0) ? 32'h0000_0004 : 32'h0000_0040, "held flag");
      @(posedge pclk);
      {pin_short, ext_clock_bad} <= 4'h0;
      cyc(6);
      wr(fl_a, 32'h0000_0044);
      rd(fl_a, 32'h0000_0000, "cleared flag");
    end
    // Shorts on irq and mcu reset pins: shutdown, restart to boot target
    for (i = 0; i < 2; i++)
    begin
      bt = $urandom_range(3, 0);
      wr(ctrl_a, {30'h0, bt});
      @(posedge pclk);
      pin_short <= 3'b001 << i;
      for (n = 0; n < 20 && regulators_off !== 1'b1; n++) @(posedge pclk);
      pin_short <= 3'b000;
      chk(gpio_low, 1'b1, "gpio low");
      for (n = 0; n < 300 && startup_req !== 1'b1; n++) @(posedge pclk);
      chk(n > `FEIR_SHUT_CYC - 3 && n < 300, 1'b1, "shutdown length");
      chk(boot_target_state, bt, "boot target");
      rd(fl_a, 32'h1 << i, "readback flag");
      wr(fl_a, 32'h0000_0003);
    end
    // Error monitor escalation with delays 4 and 6, then warm reset
    wr(`FEIR_OFF_DELAY, 32'h0006_0004);
    wr(ctrl_a, 32'h0000_0008);
    @(posedge pclk);
    op_state <= $urandom_range(3, 0);
    err_active <= 1'b1;
    for (n = 0; n < 60 && err_mon_reset_req !== 1'b1; n++) @(posedge pclk);
    chk(n > 10 && n < 60, 1'b1, "escalation delay");
    chk(drive_enable_out, 1'b0, "drive off");
    cyc(2);
    chk({mcu_reset_out_n, soc_reset_out_n}, 2'b00, "warm reset");
    rd(fl_a, 32'h0000_0018, "hidden flag");
    @(posedge pclk);
    err_active <= 1'b0;
    for (n = 0; n < 200 && restore_req !== 1'b1; n++) @(posedge pclk);
    chk(n < 200, 1'b1, "warm length");
    chk(restore_state, op_state, "restore state");
    rd(fl_a, 32'h0000_0038, "monitor flags");
    wr(fl_a, 32'h0000_0038);
    // Watchdog: fail limit 3, reset limit 9; its flags ignore the mask
    wr(mask_a, 32'h0000_03FF);
    rd(mask_a, 32'h0000_00FF, "mask width");
    wr(ctrl_a, 32'h0000_9300);
    @(posedge pclk);
    wdog_fail_count <= $urandom_range(8, 4);
    cyc(3);
    chk({drive_enable_out, irq_out_n}, 2'b00, "wdog fail");
    rd(fl_a, 32'h0000_0100, "wdog flag");
    wr(fl_a, 32'h0000_0100);
    chk(drive_enable_out, 1'b0, "drive held");
    @(posedge pclk);
    wdog_fail_count <= 4'h2;
    cyc(3);
    chk(drive_enable_out, 1'b1, "drive back");
    wr(mask_a, 32'h0000_0000);
    for (i = 0; i < 2; i++)
    begin
      wr(ctrl_a, 32'h0000_9300 | (i << 4));
      @(posedge pclk);
      wdog_fail_count <= 4'hA;
      for (n = 0; n < 8 && wdog_reset_req !== 1'b1; n++) @(posedge pclk);
      chk(n < 8, i, "wdog reset request");
      for (n = 0; n < 200 && i == 1 && restore_req !== 1'b1; n++) @(posedge pclk);
      chk(n < 200, 1'b1, "wdog warm length");
      rd(fl_a, 32'h0000_0300, "wdog flags");
      wr(fl_a, 32'h0000_0300);
      @(posedge pclk);
      wdog_fail_count <= 4'h0;
    end
    // Pwm mode: violation pulse, then error count over limit past the first delay only
    wr(ctrl_a, 32'h0000_0004);
    @(posedge pclk) pwm_violation <= 1'b1;
    @(posedge pclk) pwm_violation <= 1'b0;
    cyc(2);
    rd(fl_a, 32'h0000_0008, "pwm detect");
    wr(fl_a, 32'h0000_0008);
    @(posedge pclk) err_count_limit <= 16'($urandom_range(100, 1));
    @(posedge pclk) pwm_err_count <= err_count_limit + 16'h0001;
    cyc(8);
    pwm_err_count <= 16'h0000;
    rd(fl_a, 32'h0000_0010, "pwm fail");
    wr(fl_a, 32'h0000_0010);
    rd(fl_a, 32'h0000_0000, "pwm clear");
    test_done();
  end
endmodule
`default_nettype wire
